// >>> sbl_loader.sv
// Function
// - Time low period of first boot character
// - Low period spans nine bits, set rate
// - Send one zero byte when aligned
// - Clock range limits alignment accuracy
// - Boot work RAM region kept reserved
// - Download into 0xC00-byte RAM window
// - Wait 100 clocks before measuring
// - Erase flash unless all blank
// - Disable serial, keep divisor at handover
// - Transmit pin driven high at handover
// - Latch boot state until external reset
// - Watchdog reset keeps boot latch, restarts
// - User program mode from mode and supply
// - Mask watchdog reset output under 12 V
// - No flash reads during erase
// - Jump to mode dependent RAM start
`include "sbl_defines.svh"
module sbl_loader #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic boot_serial_rx,
	output logic boot_serial_tx,
	output logic boot_serial_tx_oe,
	input wire logic mode_select_pin_two_hv,
	input wire logic [1:0] mode_pins_low,
	input wire logic vpp_hv,
	input wire logic wdt_overflow,
	output logic wdt_reset_out,
	output logic flash_check_req,
	input wire logic flash_check_done,
	input wire logic flash_is_blank,
	output logic flash_erase_req,
	input wire logic flash_erase_done,
	output sbl_pkg::sbl_ram_t ram_wr,
	output logic jump_req,
	output logic [23:0] jump_addr,
	output logic user_prog_mode,
	output logic boot_active
);
	sbl_pkg::sbl_st_t r, n;

	// ====================
	// Helpers
	function automatic logic [19:0] div9(input logic [19:0] c);
		logic [20:0] s;
		s = {1'b0, c} + `SBL_ROUND_HALF;
		s = s / `SBL_LOW_BITS;
		if (s == 21'h0) begin
			s = 21'h1;
		end
		return 20'(s - 21'h1);
	endfunction : div9

	function automatic logic [23:0] win_base(input logic [1:0] m);
		return (m == `SBL_MODE6) ? `SBL_WIN_LO_M6 : `SBL_WIN_LO_M57;
	endfunction : win_base

	function automatic logic [33:0] rdec(input logic [7:0] a, input sbl_pkg::sbl_st_t s);
		logic [31:0] d;
		d = 32'h0;
		d[3:0] = s.st;
		d[`SBL_ST_LATCH_BIT] = s.latched;
		d[6:5] = s.mode;
		d[`SBL_ST_UPM_BIT] = s.upm;
		d[`SBL_ST_ERS_BIT] = s.ers;
		unique case (a)
			`SBL_STATUS_OFS: return {`SBL_RESP_OKAY, d};
			`SBL_DIV_OFS: return {`SBL_RESP_OKAY, 12'h0, s.div};
			`SBL_LEN_OFS: return {`SBL_RESP_OKAY, 20'h0, s.llen};
			`SBL_SERCTL_OFS: return {`SBL_RESP_OKAY, 28'h0, s.tout, s.tdir, s.te, s.re};
			`SBL_WDTCTL_OFS: return {`SBL_RESP_OKAY, 31'h0, s.watchdog_reset_out_enable};
			default: return {`SBL_RESP_SLVERR, 32'h0};
		endcase
	endfunction : rdec

	// ====================
	// Next state
	always_comb begin
		logic [11:0] len;
		len = 12'h0;
		n = r;
		n.ram.we = 1'b0;
		n.jump = 1'b0;
		n.rdone = 1'b0;
		// Transmitter: start bit, eight data, stop
		if (r.tbusy) begin
			if (r.tcnt == r.div) begin
				n.tcnt = 20'h0;
				n.tsh = {1'b1, r.tsh[9:1]};
				n.tbit = r.tbit + 4'h1;
				if (r.tbit == 4'h9) begin
					n.tbusy = 1'b0;
				end
			end else begin
				n.tcnt = r.tcnt + 20'h1;
			end
		end
		// Receiver samples at mid bit; a bad stop bit drops the byte
		if (!r.rbusy) begin
			if (r.re && !boot_serial_rx && (r.st == sbl_pkg::S_W55 || r.st == sbl_pkg::S_LOAD)) begin
				n.rbusy = 1'b1;
				n.rbit = 4'h0;
				n.rcnt = {1'b0, r.div[19:1]};
			end
		end else if (r.rcnt != 20'h0) begin
			n.rcnt = r.rcnt - 20'h1;
		end else begin
			n.rcnt = r.div;
			n.rbit = r.rbit + 4'h1;
			if (r.rbit == 4'h0) begin
				n.rbusy = !boot_serial_rx;
			end else if (r.rbit <= 4'h8) begin
				n.rsh = {boot_serial_rx, r.rsh[7:1]};
			end else begin
				n.rbusy = 1'b0;
				n.rdone = boot_serial_rx;
			end
		end
		unique case (r.st)
			sbl_pkg::S_CAPT: begin
				// Straps are caught here, after release, not inside reset
				n.latched = mode_select_pin_two_hv && vpp_hv && (mode_pins_low != 2'h0);
				n.mode = mode_pins_low;
				n.st = n.latched ? sbl_pkg::S_WAIT : sbl_pkg::S_USER;
			end
			sbl_pkg::S_WAIT: begin
				n.cnt = r.cnt + 20'h1;
				if (r.cnt == `SBL_READY_STATES - 20'h1) begin
					n.st = sbl_pkg::S_IDLE;
					n.re = 1'b1;
					n.te = 1'b1;
				end
			end
			sbl_pkg::S_IDLE: begin
				if (!boot_serial_rx) begin
					n.st = sbl_pkg::S_MEAS;
					n.cnt = 20'h1;
				end
			end
			sbl_pkg::S_MEAS: begin
				if (!boot_serial_rx) begin
					if (r.cnt != 20'hfffff) begin
						n.cnt = r.cnt + 20'h1;
					end
				end else begin
					// Accuracy is only as good as cycles per bit allow
					n.div = div9(r.cnt);
					n.st = sbl_pkg::S_TXZ;
					n.tbusy = 1'b1;
					n.tbit = 4'h0;
					n.tcnt = 20'h0;
					n.tsh = {1'b1, `SBL_ALIGN_DONE_BYTE, 1'b0};
				end
			end
			sbl_pkg::S_TXZ: begin
				if (!r.tbusy) begin
					n.st = sbl_pkg::S_W55;
				end
			end
			sbl_pkg::S_W55: begin
				// Anything but the ack is ignored; the host resets on failure
				if (r.rdone && r.rsh == `SBL_HOST_ACK_BYTE) begin
					n.st = sbl_pkg::S_CHK;
					n.chk = 1'b1;
				end
			end
			sbl_pkg::S_CHK: begin
				if (flash_check_done) begin
					n.chk = 1'b0;
					n.lcnt = 12'h0;
					n.ers = !flash_is_blank;
					n.st = flash_is_blank ? sbl_pkg::S_LOAD : sbl_pkg::S_ERS;
				end
			end
			sbl_pkg::S_ERS: begin
				if (flash_erase_done) begin
					n.ers = 1'b0;
					n.st = sbl_pkg::S_LOAD;
				end
			end
			sbl_pkg::S_LOAD: begin
				if (r.rdone) begin
					n.ram.we = 1'b1;
					n.ram.addr = win_base(r.mode) + 24'(r.lcnt);
					n.ram.data = r.rsh;
					n.lcnt = r.lcnt + 12'h1;
					if (r.lcnt == r.llen - 12'h1) begin
						n.st = sbl_pkg::S_HAND;
					end
				end
			end
			sbl_pkg::S_HAND: begin
				n.re = 1'b0;
				n.te = 1'b0;
				n.tdir = 1'b1;
				n.tout = 1'b1;
				n.jump = 1'b1;
				n.jaddr = (r.mode == `SBL_MODE7) ? `SBL_JUMP_M7 : `SBL_JUMP_M56;
				n.st = sbl_pkg::S_USER;
			end
			sbl_pkg::S_USER: begin
				n.st = sbl_pkg::S_USER;
			end
			default: begin
				n.st = sbl_pkg::S_CAPT;
			end
		endcase
		// Watchdog restart keeps the boot latch whatever the pins say
		if (wdt_overflow && r.latched) begin
			n.st = sbl_pkg::S_WAIT;
			n.cnt = 20'h0;
			n.tbusy = 1'b0;
			n.rbusy = 1'b0;
			n.chk = 1'b0;
			n.ers = 1'b0;
			n.re = 1'b0;
			n.te = 1'b0;
			n.tdir = 1'b0;
			n.tout = 1'b0;
		end
		n.upm = vpp_hv && !mode_select_pin_two_hv && (mode_pins_low != 2'h0);
		n.wdto = wdt_overflow && r.watchdog_reset_out_enable && !vpp_hv;
		n.txd = n.te ? (n.tbusy ? n.tsh[0] : 1'b1) : n.tout;
		n.oe = n.te | n.tdir;
		// ====================
		// AXI4-Lite slave, one write and one read at a time
		if (s_axi_awvalid && r.awr) begin
			n.awg = 1'b1;
			n.awa = 8'(s_axi_awaddr);
		end
		if (s_axi_wvalid && r.wr) begin
			n.wg = 1'b1;
			n.wd = s_axi_wdata;
			n.ws = s_axi_wstrb;
		end
		if (r.awg && r.wg && !r.bv) begin
			n.awg = 1'b0;
			n.wg = 1'b0;
			n.bv = 1'b1;
			n.bresp = `SBL_RESP_OKAY;
			unique case (r.awa)
				`SBL_LEN_OFS: begin
					len = r.llen;
					if (r.ws[0]) begin
						len[7:0] = r.wd[7:0];
					end
					if (r.ws[1]) begin
						len[11:8] = r.wd[11:8];
					end
					// Window size bounds the download
					n.llen = (len == 12'h0 || len > `SBL_WIN_SIZE) ? `SBL_WIN_SIZE : len;
				end
				`SBL_WDTCTL_OFS: begin
					if (r.ws[0]) begin
						n.watchdog_reset_out_enable = r.wd[0];
					end
				end
				`SBL_STATUS_OFS, `SBL_DIV_OFS, `SBL_SERCTL_OFS: begin
					n.bresp = `SBL_RESP_OKAY;
				end
				default: begin
					n.bresp = `SBL_RESP_SLVERR;
				end
			endcase
		end
		if (r.bv && s_axi_bready) begin
			n.bv = 1'b0;
		end
		n.awr = !n.awg && !n.bv;
		n.wr = !n.wg && !n.bv;
		if (s_axi_arvalid && r.arr) begin
			n.rv = 1'b1;
			{n.rresp, n.rd} = rdec(8'(s_axi_araddr), r);
		end
		if (r.rv && s_axi_rready) begin
			n.rv = 1'b0;
		end
		n.arr = !n.rv;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.st <= sbl_pkg::S_CAPT;
			r.txd <= 1'b1;
			r.llen <= `SBL_LEN_RST;
			r.awr <= 1'b1;
			r.wr <= 1'b1;
			r.arr <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ====================
	// Outputs
	assign s_axi_awready = r.awr;
	assign s_axi_wready = r.wr;
	assign s_axi_bvalid = r.bv;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arr;
	assign s_axi_rvalid = r.rv;
	assign s_axi_rdata = r.rd;
	assign s_axi_rresp = r.rresp;
	assign boot_serial_tx = r.txd;
	assign boot_serial_tx_oe = r.oe;
	assign wdt_reset_out = r.wdto;
	assign flash_check_req = r.chk;
	assign flash_erase_req = r.ers;
	assign ram_wr = r.ram;
	assign jump_req = r.jump;
	assign jump_addr = r.jaddr;
	assign user_prog_mode = r.upm;
	assign boot_active = r.latched;

	// ====================
	// Checks
	chk_ready_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(r.st == sbl_pkg::S_IDLE) |-> $past(r.cnt) == `SBL_READY_STATES - 20'h1)
		else $error("measurement armed early");
	chk_meas_start: assert property (@(posedge aclk) disable iff (!aresetn)
		(r.st == sbl_pkg::S_IDLE && !boot_serial_rx && !wdt_overflow) |=> r.st == sbl_pkg::S_MEAS)
		else $error("low period not timed");
	chk_div_round: assert property (@(posedge aclk) disable iff (!aresetn)
		(r.st == sbl_pkg::S_MEAS && boot_serial_rx && !wdt_overflow) |=> r.div == div9($past(r.cnt)))
		else $error("divisor not count over nine");
	chk_zero_byte: assert property (@(posedge aclk) disable iff (!aresetn)
		(r.st == sbl_pkg::S_TXZ && r.tbusy && r.tbit <= 4'h8) |-> !boot_serial_tx)
		else $error("alignment byte not zero");
	chk_erase_dirty: assert property (@(posedge aclk) disable iff (!aresetn)
		(r.st == sbl_pkg::S_CHK && flash_check_done && !flash_is_blank && !wdt_overflow)
		|=> (r.st == sbl_pkg::S_ERS && flash_erase_req))
		else $error("dirty flash not erased");
	chk_ram_window: assert property (@(posedge aclk) disable iff (!aresetn)
		ram_wr.we |-> (ram_wr.addr >= win_base(r.mode)
		&& ram_wr.addr < win_base(r.mode) + 24'(`SBL_WIN_SIZE)))
		else $error("download outside window");
	chk_hand_serial: assert property (@(posedge aclk) disable iff (!aresetn)
		jump_req |-> (!r.re && !r.te && $stable(r.div) && boot_serial_tx && r.tdir))
		else $error("handover pin state wrong");
	chk_jump_addr: assert property (@(posedge aclk) disable iff (!aresetn)
		jump_req |-> jump_addr == ((r.mode == `SBL_MODE7) ? `SBL_JUMP_M7 : `SBL_JUMP_M56))
		else $error("wrong jump address");
	chk_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(r.latched && r.st != sbl_pkg::S_CAPT) |=> r.latched)
		else $error("boot latch lost");
	chk_wdt_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		vpp_hv |=> !wdt_reset_out)
		else $error("watchdog reset under 12 V");
endmodule : sbl_loader

// >>> sbl_defines.svh
`ifndef SBL_DEFINES_SVH
`define SBL_DEFINES_SVH
// ====================
// Clock and timing
`define SBL_CLK_HZ 40000000
`define SBL_READY_STATES 20'd100
`define SBL_LOW_BITS 21'd9
`define SBL_ROUND_HALF 21'd4
// ====================
// Handshake bytes
`define SBL_ALIGN_DONE_BYTE 8'h00
`define SBL_HOST_ACK_BYTE 8'h55
// ====================
// Address map of the boot RAM windows
`define SBL_WIN_SIZE 12'hc00
`define SBL_WORK_SIZE 24'h0003f0
`define SBL_WORK_LO_M57 24'h0fef10
`define SBL_WORK_LO_M6 24'hffef10
`define SBL_WIN_LO_M57 24'h0ff300
`define SBL_WIN_LO_M6 24'hfff300
`define SBL_JUMP_M56 24'h0ff300
`define SBL_JUMP_M7 24'hfff300
`define SBL_MODE6 2'h2
`define SBL_MODE7 2'h3
// ====================
// Register offsets
`define SBL_STATUS_OFS 8'h00
`define SBL_DIV_OFS 8'h04
`define SBL_LEN_OFS 8'h08
`define SBL_SERCTL_OFS 8'h0c
`define SBL_WDTCTL_OFS 8'h10
// ====================
// Field positions and reset values
`define SBL_ST_LATCH_BIT 4
`define SBL_ST_UPM_BIT 7
`define SBL_ST_ERS_BIT 8
`define SBL_LEN_RST 12'hc00
`define SBL_RESP_OKAY 2'h0
`define SBL_RESP_SLVERR 2'h2
`endif

// >>> sbl_pkg.sv
package sbl_pkg;
	// ====================
	// Loader sequence, Gray coded along the boot path
	typedef enum logic [3:0] {
		S_CAPT = 4'h0, S_WAIT = 4'h1, S_IDLE = 4'h3, S_MEAS = 4'h2,
		S_TXZ = 4'h6, S_W55 = 4'h7, S_CHK = 4'h5, S_ERS = 4'h4,
		S_LOAD = 4'hc, S_HAND = 4'hd, S_USER = 4'hf
	} sbl_state_t;

	typedef struct packed {
		logic we;
		logic [23:0] addr;
		logic [7:0] data;
	} sbl_ram_t;

	typedef struct packed {
		sbl_state_t st;
		logic latched;
		logic [1:0] mode;
		logic [19:0] cnt;
		logic [19:0] div;
		logic re, te, tdir, tout, txd;
		logic oe;
		logic tbusy;
		logic [3:0] tbit;
		logic [19:0] tcnt;
		logic [9:0] tsh;
		logic rbusy, rdone;
		logic [3:0] rbit;
		logic [19:0] rcnt;
		logic [7:0] rsh;
		logic [11:0] lcnt, llen;
		logic watchdog_reset_out_enable, wdto, upm;
		logic chk, ers, jump;
		logic [23:0] jaddr;
		sbl_ram_t ram;
		logic awr, wr, arr, awg, wg, bv, rv;
		logic [1:0] bresp, rresp;
		logic [7:0] awa;
		logic [31:0] wd, rd;
		logic [3:0] ws;
	} sbl_st_t;
endpackage : sbl_pkg

// >>> sbl_host.sv
module sbl_host #(
	parameter int BIT_CYC = 100
) (
	input wire logic aclk,
	output logic rx,
	input wire logic tx
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====================
	// Serial host
	// Line idles high, as the board pull-up holds it
	initial rx = 1'b1;
	// Short bit time keeps the run small; a real host sends at 2400 to 9600 bps
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx <= f[i];
			repeat (BIT_CYC) @(posedge aclk);
		end
	endtask : send_byte
	// Returns {stop, data}; samples each bit in its middle
	task automatic recv_byte(output logic [8:0] v, output logic ok);
		int n;
		n = 0;
		v = 9'h000;
		while (tx !== 1'b0 && n < 30 * BIT_CYC) begin
			@(posedge aclk);
			n++;
		end
		ok = n < 30 * BIT_CYC;
		repeat (BIT_CYC / 2) @(posedge aclk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CYC) @(posedge aclk);
			v[i] = tx;
		end
	endtask : recv_byte
endmodule : sbl_host

// >>> sbl_loader_test.sv
module sbl_loader_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, awv, wv, bready, arv, rready, bv, rv, awr, wr, arr;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, mode;
	logic rx, tx, oe, md2hv, vpp, wdo, wro, chk_req, chk_done, ers_req, ers_done;
	logic jreq, upm, bact, blank, line_tx;
	logic chk_q = 1'b0;
	logic ers_q = 1'b0;
	logic [3:0] wstrb;
	logic [23:0] jaddr;
	logic [23:0] jseen = 24'h0;
	int ers_cnt = 0;
	sbl_pkg::sbl_ram_t ram_wr;
	logic [31:0] ramq[$];
	int err_count, cmp_count;
	sbl_loader uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rready), .boot_serial_rx(rx), .boot_serial_tx(tx),
		.boot_serial_tx_oe(oe), .mode_select_pin_two_hv(md2hv), .mode_pins_low(mode),
		.vpp_hv(vpp), .wdt_overflow(wdo), .wdt_reset_out(wro), .flash_check_req(chk_req),
		.flash_check_done(chk_done), .flash_is_blank(blank), .flash_erase_req(ers_req),
		.flash_erase_done(ers_done), .ram_wr(ram_wr), .jump_req(jreq), .jump_addr(jaddr),
		.user_prog_mode(upm), .boot_active(bact));
	sbl_host host (.aclk(aclk), .rx(rx), .tx(line_tx));
	// A released transmit line sits at the board pull-up level
	assign line_tx = oe ? tx : 1'b1;
	always #12.5 aclk = ~aclk;
	// ====================
	// Flash and RAM side responders
	// Outputs move at rising edges, so they are read at the falling edge
	always @(negedge aclk) begin
		if (ers_req === 1'b1 && ers_q !== 1'b1) ers_cnt++;
		chk_q = chk_req;
		ers_q = ers_req;
		if (ram_wr.we === 1'b1) ramq.push_back({ram_wr.addr, ram_wr.data});
		if (jreq === 1'b1) jseen = jaddr;
	end
	always @(posedge aclk) begin
		chk_done <= chk_q & ~chk_done;
		ers_done <= ers_q & ~ers_done;
	end
	// ====================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// The falling edge shows what the next rising edge samples; only the watchdog ends a wait
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_hs, w_hs, b_hs;
		b_hs = 1'b0;
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		while (!b_hs) begin
			@(negedge aclk);
			aw_hs = awv && awr === 1'b1;
			w_hs = wv && wr === 1'b1;
			b_hs = bv === 1'b1;
			r = bresp;
			@(posedge aclk);
			if (aw_hs) awv <= 1'b0;
			if (w_hs) wv <= 1'b0;
		end
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_hs, r_hs;
		r_hs = 1'b0;
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		while (!r_hs) begin
			@(negedge aclk);
			ar_hs = arv && arr === 1'b1;
			r_hs = rv === 1'b1;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar_hs) arv <= 1'b0;
		end
		rready <= 1'b0;
	endtask : axi_rd
	// ====================
	// Scenarios
	task automatic sc_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(8'h08, d, r);
		chk("len reset", d[11:0], 12'hc00);
		axi_wr(8'h08, 32'h3, r);
		axi_rd(8'h08, d, r);
		chk("len", d[11:0], 12'h003);
		// Only byte one is enabled, byte zero keeps its value
		wstrb <= 4'h2;
		axi_wr(8'h08, 32'h0bff, r);
		axi_rd(8'h08, d, r);
		chk("len strobe", d[11:0], 12'hb03);
		wstrb <= 4'hf;
		axi_wr(8'h08, 32'h3, r);
		axi_rd(8'h20, d, r);
		chk("rd unmapped", r, 2'h2);
		axi_wr(8'h20, 32'h1, r);
		chk("wr unmapped", r, 2'h2);
		axi_wr(8'h10, 32'h1, r);
	endtask : sc_regs
	task automatic sc_boot;
		logic [8:0] v;
		logic ok;
		logic [31:0] d;
		logic [1:0] r;
		// Host start bit only after the loader's settling time
		repeat (150) @(posedge aclk);
		fork
			host.send_byte(8'h00);
			host.recv_byte(v, ok);
		join
		chk("align byte", {ok, v}, 10'h300);
		// Let the alignment byte's stop bit end before answering
		repeat (60) @(posedge aclk);
		axi_rd(8'h04, d, r);
		chk("divisor", d, 32'h63);
		host.send_byte(8'h55);
		repeat (30) @(posedge aclk);
		host.send_byte(8'ha5);
		host.send_byte(8'h3c);
		host.send_byte(8'h81);
		repeat (40) @(posedge aclk);
		chk("erase", ers_cnt, 1);
		chk("ram count", ramq.size(), 3);
		chk("ram 0", ramq[0], 32'hfff300a5);
		chk("ram 2", ramq[2], 32'hfff30281);
		chk("jump", jseen, 24'h0ff300);
		axi_rd(8'h0c, d, r);
		chk("serctl", d[3:0], 4'hc);
		axi_rd(8'h04, d, r);
		chk("div kept", d, 32'h63);
		chk("tx pin", {oe, tx}, 2'h3);
		axi_rd(8'h00, d, r);
		chk("status", d[7:0], 8'h5f);
	endtask : sc_boot
	task automatic sc_mode7;
		logic [8:0] v;
		logic ok;
		logic [1:0] r;
		// Host restarts boot mode by reset, as it would after a bad alignment byte
		mode <= 2'h3;
		blank <= 1'b1;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_wr(8'h08, 32'h1, r);
		repeat (150) @(posedge aclk);
		fork
			host.send_byte(8'h00);
			host.recv_byte(v, ok);
		join
		chk("align byte 7", {ok, v}, 10'h300);
		repeat (60) @(posedge aclk);
		host.send_byte(8'h55);
		repeat (30) @(posedge aclk);
		host.send_byte(8'h7e);
		repeat (40) @(posedge aclk);
		chk("no erase", ers_cnt, 1);
		chk("ram count 7", ramq.size(), 4);
		chk("ram 3", ramq[3], 32'h0ff3007e);
		chk("jump 7", jseen, 24'hfff300);
	endtask : sc_mode7
	task automatic sc_latch;
		logic [31:0] d;
		logic [1:0] r;
		// Still boot mode here, so the reset output enable may be set
		axi_wr(8'h10, 32'h1, r);
		// Pins stop asking for boot mode, yet the restart stays in boot
		mode <= 2'h0;
		wdo <= 1'b1;
		@(posedge aclk);
		wdo <= 1'b0;
		#1 chk("wdt out masked", wro, 1'b0);
		repeat (130) @(posedge aclk);
		axi_rd(8'h00, d, r);
		chk("restart", d[7:0], 8'h73);
		vpp <= 1'b0;
		@(posedge aclk);
		wdo <= 1'b1;
		@(posedge aclk);
		wdo <= 1'b0;
		#1 chk("wdt out", wro, 1'b1);
		@(posedge aclk);
		// Enable cleared before user program mode is entered
		axi_wr(8'h10, 32'h0, r);
		md2hv <= 1'b0;
		mode <= 2'h2;
		vpp <= 1'b1;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("latch cleared", bact, 1'b0);
		chk("user prog", upm, 1'b1);
	endtask : sc_latch
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	// ====================
	// Main sequence and watchdog
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awv, wv, bready, arv, rready, wdo} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		blank = 1'b0;
		md2hv = 1'b1;
		vpp = 1'b1;
		mode = 2'h2;
		err_count = 0;
		cmp_count = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		sc_regs();
		sc_boot();
		sc_mode7();
		sc_latch();
		wrap_up();
	end
	// The whole run needs under 12000 cycles
	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		wrap_up();
	end
endmodule : sbl_loader_test
